// ===== hw/rms_ctrl.sv
// Reset, mode selection and shutdown controller top.
// Assumes pins sampled synchronous to clk and an external pull-up
// on the reset pin and the keyscan column pin.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module rms_ctrl
  import rms_pkg::*;
#(
  parameter int SHUT_MIN = SHUT_MIN_TICKS,
  parameter int SHUT_MAX = SHUT_MAX_TICKS,
  parameter int WAKE_LEN = WAKE_TICKS
)(
  // Clock and power-on reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Open-drain reset pin
  input  wire logic       rst_pin_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe,
  input  wire logic       wdt_expire,
  // Three-level mode pin comparators
  input  wire logic       tri_is_high,
  input  wire logic       tri_is_low,
  // Mode outputs
  output logic            use_int_cpu,
  output logic            use_int_rom,
  output logic            ext_rom_en,
  // Block enables and power
  output logic      [7:0] blk_en_a,
  output logic      [7:0] blk_en_b,
  output logic            clocks_run,
  output logic            analog_on,
  output logic            pll_run,
  // Interrupt sources
  input  wire logic       irq_enabled,
  input  wire logic       cpu_irq_line_a,
  input  wire logic       cpu_irq_line_b,
  input  wire logic       ext_interrupt_pin_one,
  output logic            ext_int_req,
  // Processor idle and clock
  input  wire logic       cpu_idle,
  output logic            cpu_clk_en,
  output logic      [2:0] cpu_rate,
  // Keyscan column pin
  output logic            osc_enable_out,
  output logic            keyscan_column_gpo_pin_out,
  output logic            keyscan_column_gpo_pin_oe
);
  // ===========================================================
  // Declarations
  rms_seq_if             sq ();
  rms_state_e            state;
  rms_state_e            next_state;
  rms_mode_e             mode;
  logic                  mode_taken;
  logic       [7:0]      watchdog_key_reg;
  logic       [7:0]      module_enable_reg_a;
  logic       [7:0]      module_enable_reg_b;
  logic       [7:0]      cpu_clock_control_reg;
  logic       [7:0]      gp_output_control_reg;
  logic       [4:0]      rst_drive_cnt;
  logic       [10:0]     mtick_acc;
  logic                  mtick;
  logic       [16:0]     ctick_acc;
  logic                  ctick;
  logic       [6:0]      cdiv_cnt;
  logic                  gsrst;
  logic                  hold_active;
  logic                  wake_src;
  logic                  speedup;
  logic                  ext_pin_q;
  logic                  seq_abort;
  logic                  wake_done;

  // ===========================================================
  // Functions
  // Decode three-level pin into operating mode
  function automatic rms_mode_e decode_mode(input logic hi, input logic lo);
    if (hi)      decode_mode = RMS_MODE_NORMAL;
    else if (lo) decode_mode = RMS_MODE_EMUL;
    else         decode_mode = RMS_MODE_EXTERNAL;
  endfunction : decode_mode

  // Mask of low bits for a clock-rate divide by two to the rate
  function automatic logic [6:0] rate_mask(input logic [2:0] r);
    rate_mask = 7'((8'h01 << r) - 8'h01);
  endfunction : rate_mask

  // Register select helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ===========================================================
  // Global reset from the sampled pin level
  assign gsrst = ~rst_pin_in;

  // ===========================================================
  // Reset pin driver; survives the pin reset so the pulse completes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_drive_cnt <= '0;
    end else if (mode == RMS_MODE_EMUL) begin
      rst_drive_cnt <= '0;
    end else if (wdt_expire ||
                 (reg_wr && hit(reg_addr, OFS_WDT_KEY) && reg_wdata == WDT_SOFT_KEY)) begin
      rst_drive_cnt <= RST_DRIVE_CYC;
    end else if (rst_drive_cnt != '0) begin
      rst_drive_cnt <= rst_drive_cnt - 1'b1;
    end
  end

  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = (rst_drive_cnt != '0);

  // ===========================================================
  // Mode capture; tracks the pin while in reset, freezes at release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_taken <= 1'b0;
      mode       <= RMS_MODE_NORMAL;
    end else if (gsrst) begin
      mode_taken <= 1'b0;
      mode       <= decode_mode(tri_is_high, tri_is_low);
    end else if (!mode_taken) begin
      mode_taken <= 1'b1;
      mode       <= decode_mode(tri_is_high, tri_is_low);
    end
  end

  // Processor and ROM routing per mode
  always_comb begin
    use_int_cpu = (mode != RMS_MODE_EMUL);
    use_int_rom = (mode == RMS_MODE_NORMAL);
    ext_rom_en  = 1'b1;                      // Expansion ROM optional in normal mode
  end

  // ===========================================================
  // Master 12.8 MHz tick by fractional accumulation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mtick_acc <= '0;
      mtick     <= 1'b0;
    end else if (mtick_acc + MTICK_STEP >= MTICK_MOD) begin
      mtick_acc <= 11'(mtick_acc + MTICK_STEP - MTICK_MOD);
      mtick     <= 1'b1;
    end else begin
      mtick_acc <= 11'(mtick_acc + MTICK_STEP);
      mtick     <= 1'b0;
    end
  end

  // ===========================================================
  // Control registers; a software write beats a hardware clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_key_reg      <= RST_WDT_KEY;
      module_enable_reg_a   <= RST_MOD_EN;
      module_enable_reg_b   <= RST_MOD_EN;
      cpu_clock_control_reg <= RST_CPU_CLK;
      gp_output_control_reg <= RST_GPO_CTL;
    end else if (gsrst) begin
      watchdog_key_reg      <= RST_WDT_KEY;
      module_enable_reg_a   <= RST_MOD_EN;
      module_enable_reg_b   <= RST_MOD_EN;
      cpu_clock_control_reg <= RST_CPU_CLK;
      gp_output_control_reg <= RST_GPO_CTL;
    end else begin
      if (seq_abort || wake_done) begin
        cpu_clock_control_reg[BIT_SHUT_REQ] <= 1'b0;
      end
      if (speedup) begin
        cpu_clock_control_reg[2:0] <= RATE_MAX;
      end
      if (reg_wr) begin
        case (reg_addr)
          OFS_WDT_KEY:  watchdog_key_reg      <= reg_wdata;
          OFS_MOD_EN_A: module_enable_reg_a   <= reg_wdata;
          OFS_MOD_EN_B: module_enable_reg_b   <= reg_wdata;
          OFS_CPU_CLK:  cpu_clock_control_reg <= reg_wdata;
          OFS_GPO_CTL:  gp_output_control_reg <= reg_wdata;
          default:      ;
        endcase
      end
    end
  end

  // ===========================================================
  // Register read, data valid the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_WDT_KEY:  reg_rdata <= watchdog_key_reg;
        OFS_MOD_EN_A: reg_rdata <= module_enable_reg_a;
        OFS_MOD_EN_B: reg_rdata <= module_enable_reg_b;
        OFS_CPU_CLK:  reg_rdata <= cpu_clock_control_reg;
        OFS_GPO_CTL:  reg_rdata <= gp_output_control_reg;
        OFS_STATUS:   reg_rdata <= {state, mode, hold_active, ext_pin_q};
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ===========================================================
  // Hold and wake qualification
  assign hold_active = cpu_clock_control_reg[BIT_HOLD_EN] & ~ext_interrupt_pin_one;
  assign wake_src    = irq_enabled & ~hold_active;

  // External interrupt one: level change in hold mode, inverted pin level otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_pin_q   <= 1'b1;
      ext_int_req <= 1'b0;
    end else begin
      ext_pin_q <= ext_interrupt_pin_one;
      if (cpu_clock_control_reg[BIT_HOLD_EN]) begin
        ext_int_req <= (ext_pin_q != ext_interrupt_pin_one);
      end else begin
        ext_int_req <= ~ext_interrupt_pin_one;
      end
    end
  end

  // ===========================================================
  // Shutdown sequencer
  assign sq.tick  = mtick;
  assign sq.clear = (state != next_state) || gsrst;

  rms_seq_timer u_timer (
    .clk  (clk),
    .nrst (nrst),
    .sq   (sq)
  );

  // Abort and completion events
  assign seq_abort = (state == RMS_ST_SHUTSQ) && wake_src;
  assign wake_done = (state == RMS_ST_WAKE) && (int'(sq.count) >= WAKE_LEN);

  // Next state; idle processor ends the sequence early after the minimum
  always_comb begin
    next_state = state;
    case (state)
      RMS_ST_RUN: begin
        if (cpu_clock_control_reg[BIT_SHUT_REQ]) begin
          next_state = RMS_ST_SHUTSQ;
        end
      end
      RMS_ST_SHUTSQ: begin
        if (wake_src) begin
          next_state = RMS_ST_RUN;
        end else if ((int'(sq.count) >= SHUT_MIN && cpu_idle) ||
                     int'(sq.count) >= SHUT_MAX) begin
          next_state = RMS_ST_STATIC;
        end
      end
      RMS_ST_STATIC: begin
        if (wake_src) begin
          next_state = RMS_ST_WAKE;
        end
      end
      RMS_ST_WAKE: begin
        if (wake_done) begin
          next_state = RMS_ST_RUN;
        end
      end
      default: next_state = RMS_ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= RMS_ST_RUN;
    end else if (gsrst) begin
      state <= RMS_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ===========================================================
  // Power outputs; registers keep contents so wake restores state
  always_comb begin
    clocks_run     = (state == RMS_ST_RUN) || (state == RMS_ST_SHUTSQ); // Held off until wake ends
    osc_enable_out = (state != RMS_ST_STATIC);
    pll_run        = osc_enable_out;
    analog_on      = (state == RMS_ST_RUN) || (state == RMS_ST_SHUTSQ);
    blk_en_a       = clocks_run ? module_enable_reg_a : '0;
    blk_en_b       = clocks_run ? module_enable_reg_b : '0;
  end

  // Keyscan column pin: oscillator enable, output seven or column input
  always_comb begin
    if (gp_output_control_reg[BIT_OSC_SEL]) begin
      keyscan_column_gpo_pin_out = osc_enable_out;
      keyscan_column_gpo_pin_oe  = 1'b1;
    end else if (gp_output_control_reg[BIT_GPO_SEL]) begin
      keyscan_column_gpo_pin_out = gp_output_control_reg[BIT_GPO_VAL];
      keyscan_column_gpo_pin_oe  = 1'b1;
    end else begin
      keyscan_column_gpo_pin_out = 1'b0;
      keyscan_column_gpo_pin_oe  = 1'b0; // Pull-up holds it high
    end
  end

  // ===========================================================
  // Processor clock: 9.216 MHz base divided by two to the rate
  assign speedup  = cpu_clock_control_reg[BIT_SPEEDUP] & (cpu_irq_line_a | cpu_irq_line_b);
  assign cpu_rate = speedup ? RATE_MAX : cpu_clock_control_reg[2:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctick_acc <= '0;
      ctick     <= 1'b0;
    end else if (ctick_acc >= CTICK_MOD - CTICK_STEP) begin // Sum would overflow 17 bits
      ctick_acc <= 17'(ctick_acc + CTICK_STEP - CTICK_MOD);
      ctick     <= 1'b1;
    end else begin
      ctick_acc <= 17'(ctick_acc + CTICK_STEP);
      ctick     <= 1'b0;
    end
  end

  // Rate divider; clock stops entirely while static or waking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cdiv_cnt   <= '0;
      cpu_clk_en <= 1'b0;
    end else if (!clocks_run) begin
      cdiv_cnt   <= '0;
      cpu_clk_en <= 1'b0;
    end else if (ctick) begin
      cdiv_cnt   <= 7'(cdiv_cnt + 1'b1);
      cpu_clk_en <= ((cdiv_cnt & rate_mask(cpu_rate)) == '0);
    end else begin
      cpu_clk_en <= 1'b0;
    end
  end
endmodule : rms_ctrl

// ===== hw/rms_pkg.sv
// Package of constants for the reset, mode and shutdown controller.
// Assumes a single 125 MHz clock and an 8-bit register port.
package rms_pkg;
  // ===========================================================
  // Register offsets
  localparam logic [7:0] OFS_WDT_KEY  = 8'h00;
  localparam logic [7:0] OFS_MOD_EN_A = 8'h01;
  localparam logic [7:0] OFS_MOD_EN_B = 8'h02;
  localparam logic [7:0] OFS_CPU_CLK  = 8'h03;
  localparam logic [7:0] OFS_GPO_CTL  = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h05;

  // ===========================================================
  // Field positions and reset values
  localparam int          BIT_SHUT_REQ   = 7;
  localparam int          BIT_HOLD_EN    = 5;
  localparam int          BIT_SPEEDUP    = 4;
  localparam int          BIT_GPO_SEL    = 6;
  localparam int          BIT_OSC_SEL    = 4;
  localparam int          BIT_GPO_VAL    = 0;
  localparam logic [7:0]  WDT_SOFT_KEY   = 8'h00;
  localparam logic [7:0]  RST_WDT_KEY    = 8'hFF;
  localparam logic [7:0]  RST_MOD_EN     = 8'h00;
  localparam logic [7:0]  RST_CPU_CLK    = 8'h00;
  localparam logic [7:0]  RST_GPO_CTL    = 8'h10;
  localparam logic [2:0]  RATE_MAX       = 3'h0;

  // ===========================================================
  // Timing: master 12.8 MHz tick from 125 MHz (128 / 1250)
  localparam logic [10:0] MTICK_STEP     = 11'h080;
  localparam logic [10:0] MTICK_MOD      = 11'h4E2;
  // Processor base 9.216 MHz from 125 MHz (9216 / 125000)
  localparam logic [16:0] CTICK_STEP     = 17'h02400;
  localparam logic [16:0] CTICK_MOD      = 17'h1E848;
  localparam int          SHUT_MIN_NS    = 3560000;
  localparam int          SHUT_MAX_NS    = 7200000;
  localparam int          WAKE_NS        = 3560000;
  localparam int          MCLK_KHZ       = 12800;
  localparam int          SHUT_MIN_TICKS = (SHUT_MIN_NS / 1000) * MCLK_KHZ / 1000;
  localparam int          SHUT_MAX_TICKS = (SHUT_MAX_NS / 1000) * MCLK_KHZ / 1000;
  localparam int          WAKE_TICKS     = (WAKE_NS / 1000) * MCLK_KHZ / 1000;
  localparam int          TMR_W          = 17;
  localparam logic [4:0]  RST_DRIVE_CYC  = 5'h10;

  // ===========================================================
  // Types
  typedef enum logic [1:0] {
    RMS_MODE_NORMAL   = 2'h0,
    RMS_MODE_EXTERNAL = 2'h1,
    RMS_MODE_EMUL     = 2'h2
  } rms_mode_e;

  typedef enum logic [3:0] {
    RMS_ST_RUN    = 4'h1,
    RMS_ST_SHUTSQ = 4'h2,
    RMS_ST_STATIC = 4'h4,
    RMS_ST_WAKE   = 4'h8
  } rms_state_e;
endpackage : rms_pkg

// ===== hw/rms_seq_if.sv
// Carrier between the controller and its sequence timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rms_seq_if;
  import rms_pkg::*;
  logic             clear;
  logic             tick;
  logic [TMR_W-1:0] count;

  modport ctl (output clear, output tick, input count);
  modport tmr (input clear, input tick, output count);
endinterface : rms_seq_if

// ===== hw/rms_seq_timer.sv
// Sequence timer counting master-clock ticks.
// Assumes tick is a one-cycle enable at the master rate.
`timescale 1ns/1ps
module rms_seq_timer
  import rms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Timer link
  rms_seq_if.tmr   sq
);
  // ===========================================================
  // Tick counter, saturating so it never wraps in a long stay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sq.count <= '0;
    end else if (sq.clear) begin
      sq.count <= '0;
    end else if (sq.tick && (sq.count != {TMR_W{1'b1}})) begin
      sq.count <= sq.count + 1'b1;
    end
  end
endmodule : rms_seq_timer

// ===== verification/rms_board.sv
// Board model: reset pull-up, battery monitor and gated oscillator.
// Assumes the bench commands the push button and the battery state.
`timescale 1ns/1ps
module rms_board (
  // Commands from the bench
  input  wire logic ext_rst_n,
  input  wire logic batt_ok,
  // Device pins
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe,
  input  wire logic col_out,
  input  wire logic col_oe,
  output logic      rst_pin_in,
  output logic      ext_interrupt_pin_one,
  output logic      osc_running
);
  // Open-drain wire with pull-up; the button also pulls it low
  assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) & ext_rst_n;
  // Monitor pulls the hold line low on a weak battery
  assign ext_interrupt_pin_one = batt_ok;
  // Oscillator gated by the column pin, pulled high when released
  assign osc_running = col_oe ? col_out : 1'b1;
endmodule : rms_board

// ===== verification/rms_ctrl_properties.sv
// Concurrent checks on the ports of the reset, mode and shutdown controller.
// Assumes one 125 MHz clock and sequence counts given in 12.8 MHz ticks.
`timescale 1ns/1ps
module rms_ctrl_properties
  import rms_pkg::*;
#(
  parameter int SHUT_MIN = SHUT_MIN_TICKS,
  parameter int SHUT_MAX = SHUT_MAX_TICKS,
  parameter int WAKE_LEN = WAKE_TICKS
)(
  // Clock, reset and register writes
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // Reset pin and mode
  input wire logic       rst_pin_in,
  input wire logic       rst_pin_oe,
  input wire logic       wdt_expire,
  input wire logic       use_int_cpu,
  input wire logic       use_int_rom,
  // Power and clocks
  input wire logic [7:0] blk_en_a,
  input wire logic [7:0] blk_en_b,
  input wire logic       clocks_run,
  input wire logic       analog_on,
  input wire logic       pll_run,
  input wire logic       cpu_clk_en,
  input wire logic [2:0] cpu_rate,
  input wire logic       osc_enable_out,
  input wire logic       keyscan_column_gpo_pin_out,
  // Interrupts
  input wire logic       cpu_irq_line_a,
  input wire logic       cpu_irq_line_b,
  input wire logic       ext_interrupt_pin_one
);
  // ==========================================================
  // Helper state
  // Two ticks of slack: the tick phase at the start is unknown
  localparam int SH_LO = (SHUT_MIN - 2) * 1250 / 128;
  localparam int SH_HI = (SHUT_MAX + 2) * 1250 / 128;
  localparam int WK_LO = (WAKE_LEN - 2) * 1250 / 128;
  localparam int WK_HI = (WAKE_LEN + 2) * 1250 / 128;
  logic spd, hold_q, osc_sel;
  int   shut_cnt, wake_cnt, oe_cnt, hi_cnt;

  // Shadow of control bits; speedup only rewrites the rate field
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {spd, hold_q, osc_sel} <= 3'b001;
    end else if (!rst_pin_in) begin
      {spd, hold_q, osc_sel} <= 3'b001;
    end else if (reg_wr && reg_addr == OFS_CPU_CLK) begin
      spd    <= reg_wdata[BIT_SPEEDUP];
      hold_q <= reg_wdata[BIT_HOLD_EN];
    end else if (reg_wr && reg_addr == OFS_GPO_CTL) begin
      osc_sel <= reg_wdata[BIT_OSC_SEL];
    end
  end

  // Cycle counters for the timed sequences
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shut_cnt <= 0;
      wake_cnt <= 0;
      oe_cnt   <= 0;
      hi_cnt   <= 0;
    end else begin
      shut_cnt <= (reg_wr && reg_addr == OFS_CPU_CLK) ? 0 : shut_cnt + 1;
      wake_cnt <= (osc_enable_out && !clocks_run) ? wake_cnt + 1 : 0;
      oe_cnt   <= rst_pin_oe ? oe_cnt + 1 : 0;
      hi_cnt   <= !rst_pin_in ? 0 : (hi_cnt < 3) ? hi_cnt + 1 : 3;
    end
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_key_write;
    reg_wr && rst_pin_in && reg_addr == OFS_WDT_KEY && reg_wdata == WDT_SOFT_KEY;
  endsequence
  sequence s_drive;
    rst_pin_oe [*8];
  endsequence

  a_wdt_drive: assert property (wdt_expire && use_int_cpu |=> s_drive)
    else $error("reset pin not driven after watchdog expiry");
  a_soft_key: assert property (use_int_cpu ##0 s_key_write |=> s_drive)
    else $error("reset pin not driven after key write");
  a_drive_len: assert property ($fell(rst_pin_oe) |-> oe_cnt >= int'(RST_DRIVE_CYC))
    else $error("reset pin drive too short");
  a_emul_quiet: assert property (!use_int_cpu |-> !rst_pin_oe)
    else $error("reset pin driven in emulation mode");
  a_pin_reset: assert property (!rst_pin_in |=> blk_en_a == 8'h00 && blk_en_b == 8'h00 && osc_enable_out)
    else $error("reset pin low did not restore defaults");
  a_static_off: assert property (!osc_enable_out |-> !clocks_run && !analog_on && blk_en_a == 8'h00)
    else $error("circuits active while static");
  a_cpu_gate: assert property (!clocks_run && !$past(clocks_run) |-> !cpu_clk_en)
    else $error("processor clock runs while clocks stopped");
  a_pll_follow: assert property (osc_enable_out |-> pll_run)
    else $error("pll idle with oscillator enabled");
  a_osc_pin: assert property (osc_sel |-> keyscan_column_gpo_pin_out == osc_enable_out)
    else $error("column pin does not show oscillator enable");
  a_speed_up: assert property (spd && (cpu_irq_line_a || cpu_irq_line_b) |=> cpu_rate == RATE_MAX)
    else $error("no speedup on interrupt");
  a_hold_mask: assert property (hold_q && !ext_interrupt_pin_one && !osc_enable_out |=> !osc_enable_out)
    else $error("woke while hold active");
  a_shut_window: assert property ($fell(clocks_run) |-> shut_cnt >= SH_LO && shut_cnt <= SH_HI)
    else $error("shutdown length out of range");
  a_wake_len: assert property ($rose(clocks_run) |-> wake_cnt >= WK_LO && wake_cnt <= WK_HI)
    else $error("wake-up length out of range");
  a_mode_fixed: assert property (hi_cnt == 3 |-> $stable(use_int_cpu) && $stable(use_int_rom))
    else $error("mode changed after reset release");
endmodule : rms_ctrl_properties

// ===== verification/rms_ctrl_tb.sv
// Self-checking bench for the reset, mode and shutdown controller.
// Assumes short sequence counts of 20/40/20 master ticks.
`timescale 1ns/1ps
module rms_ctrl_tb;
  import rms_pkg::*;
  localparam int SMIN = 20;
  localparam int SMAX = 40;
  localparam int WLEN = 20;
  logic       clk, nrst, reg_wr, reg_rd, wdt_expire, tri_is_high, tri_is_low;
  logic       rst_pin_in, rst_pin_out, rst_pin_oe, use_int_cpu, use_int_rom, ext_rom_en;
  logic       clocks_run, analog_on, pll_run, irq_enabled, cpu_irq_line_a, cpu_irq_line_b;
  logic       ext_interrupt_pin_one, ext_int_req, cpu_idle, cpu_clk_en, osc_enable_out;
  logic       keyscan_column_gpo_pin_out, keyscan_column_gpo_pin_oe, ext_rst_n, batt_ok, osc_running;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, blk_en_a, blk_en_b;
  logic [2:0] cpu_rate;
  int         mismatches, checked;

  rms_ctrl #(.SHUT_MIN(SMIN), .SHUT_MAX(SMAX), .WAKE_LEN(WLEN)) i_rms_ctrl (.*);
  rms_board i_rms_board (.ext_rst_n(ext_rst_n), .batt_ok(batt_ok), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .col_out(keyscan_column_gpo_pin_out), .col_oe(keyscan_column_gpo_pin_oe),
    .rst_pin_in(rst_pin_in), .ext_interrupt_pin_one(ext_interrupt_pin_one), .osc_running(osc_running));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chkb
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // One-cycle pulse: 0 irq, 1 watchdog, 2 and 3 processor lines
  task automatic pulse(input int w);
    @(posedge clk);
    {cpu_irq_line_b, cpu_irq_line_a, wdt_expire, irq_enabled} <= 4'h1 << w;
    @(posedge clk);
    {cpu_irq_line_b, cpu_irq_line_a, wdt_expire, irq_enabled} <= 4'h0;
    #1;
  endtask : pulse
  // Bounded wait on oscillator enable (0) or clocks running (1)
  task automatic wt(input logic sel, input logic lvl, output int n);
    n = 0;
    while ((sel ? clocks_run : osc_enable_out) !== lvl && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 2000) begin
      mismatches++;
      end_of_test();
    end
  endtask : wt

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] d;
    for (int i = 1; i < 6; i++) begin
      rd(8'(i + 31 * (i / 5)), d);
      chk(d, (i == 4) ? RST_GPO_CTL : RST_MOD_EN);
    end
    chkb(keyscan_column_gpo_pin_out & keyscan_column_gpo_pin_oe, 1'b1);
    chkb(pll_run, 1'b1);
  endtask : t_reset
  task automatic t_regs;
    logic [7:0] d;
    wr(OFS_MOD_EN_A, 8'hA5);
    wr(OFS_MOD_EN_B, 8'h3C);
    chk(blk_en_a ^ blk_en_b, 8'h99);
    wr(OFS_CPU_CLK, 8'h03);
    chk({5'h0, cpu_rate}, 8'h03);
    for (int j = 2; j < 4; j++) begin
      wr(OFS_CPU_CLK, 8'h13);
      pulse(j);
      chk({5'h0, cpu_rate}, 8'h00);
    end
    rd(OFS_CPU_CLK, d);
    chk(d, 8'h10);
  endtask : t_regs
  task automatic t_sreset;
    wr(OFS_WDT_KEY, WDT_SOFT_KEY);
    chkb(rst_pin_oe, 1'b1);
    cyc(16);
    chkb(rst_pin_oe, 1'b0);
    chk(blk_en_a, 8'h00);
    pulse(1);
    chkb(rst_pin_oe, 1'b1);
    cyc(20);
  endtask : t_sreset
  task automatic t_shut(input logic idle, input int lo, input int hi);
    int         n;
    logic [7:0] d;
    wr(OFS_MOD_EN_A, 8'h5A);
    cpu_idle <= idle;
    wr(OFS_CPU_CLK, 8'h80);
    wt(1'b0, 1'b0, n);
    chkb(n >= lo && n <= hi, 1'b1);
    chk({5'h0, clocks_run, analog_on, osc_running}, 8'h00);
    pulse(0);
    wt(1'b1, 1'b1, n);
    chkb(n >= WLEN * 9 && n <= WLEN * 10 + 8, 1'b1);
    chk(blk_en_a, 8'h5A);
    rd(OFS_CPU_CLK, d);
    chk(d, 8'h00);
  endtask : t_shut
  task automatic t_abort;
    logic [7:0] d;
    wr(OFS_CPU_CLK, 8'h80);
    cyc(50);
    pulse(0);
    rd(OFS_CPU_CLK, d);
    chk(d, 8'h00);
    cyc(450);
    chkb(clocks_run & analog_on, 1'b1);
  endtask : t_abort
  task automatic t_hold;
    int         n;
    logic [7:0] d;
    batt_ok <= 1'b0;
    cyc(3);
    chkb(ext_int_req, 1'b1);
    batt_ok <= 1'b1;
    cyc(3);
    chkb(ext_int_req, 1'b0);
    batt_ok <= 1'b0;
    cpu_idle <= 1'b1;
    wr(OFS_CPU_CLK, 8'hA0);
    wt(1'b0, 1'b0, n);
    pulse(0);
    cyc(300);
    chkb(osc_enable_out, 1'b0);
    batt_ok <= 1'b1;
    cyc(3);
    pulse(0);
    wt(1'b1, 1'b1, n);
    rd(OFS_CPU_CLK, d);
    chk(d, 8'h20);
  endtask : t_hold
  task automatic t_modes;
    logic [7:0] d;
    for (int m = 0; m < 3; m++) begin
      tri_is_high <= (m == 0);
      tri_is_low  <= (m == 2);
      ext_rst_n   <= 1'b0;
      cyc(3);
      ext_rst_n   <= 1'b1;
      cyc(3);
      tri_is_high <= 1'b0;
      tri_is_low  <= 1'b0;
      rd(OFS_STATUS, d);
      chk({6'h0, d[3:2]}, 8'(m));
      chk({5'h0, use_int_cpu, use_int_rom, ext_rom_en}, 8'({m != 2, m == 0, 1'b1}));
      pulse(1);
      chkb(rst_pin_oe, m != 2);
      cyc(20);
    end
  endtask : t_modes

  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, wdt_expire, tri_is_low, irq_enabled} = 6'h00;
    {cpu_irq_line_a, cpu_irq_line_b, cpu_idle} = 3'h0;
    {tri_is_high, ext_rst_n, batt_ok} = 3'h7;
    {reg_addr, reg_wdata} = 16'h0000;
    mismatches = 0;
    checked    = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cyc(2);
    t_reset();
    t_regs();
    t_sreset();
    t_shut(1'b1, 180, 220);
    t_shut(1'b0, 370, 420);
    t_abort();
    t_hold();
    t_modes();
    end_of_test();
  end
endmodule : rms_ctrl_tb

bind rms_ctrl rms_ctrl_properties #(.SHUT_MIN(SHUT_MIN), .SHUT_MAX(SHUT_MAX), .WAKE_LEN(WAKE_LEN))
  i_rms_ctrl_properties (.*);
